// *** hdl/focp_core.sv ***
`timescale 1ns/1ns
// Contract
// - Clamp d-axis regulator output to programmed limit; 1430 is full modulation.
// - Clamp q-axis output to static limit; static limit caps the dynamic limit.
// - Direction 1 spins positive, 0 spins negative.
// - Signed torque command -16384..16383 feeds inner loop; 4095 is rated current.
// - Zero-speed fault when speed below half minimum for over two seconds.
// - Bit 5 of fault-disable mask skips zero-speed check.
// - Minimum speed 1..255, scaled by top speed over 2048, clamps command from below.
// - PLL integral limited to value times switching frequency times multiplier over 2^13.
// - Multiplier 4 if quad flag, else 2 if double flag, else 1.
// - Current vector at rotor angle plus 90 degrees plus gain-scaled advancement.
// - Advancement capped at programmed maximum, 0.17578 degrees per count.
// - Lag angle is estimated rotor frequency times lag time constant.
// - Flux estimates load from signed start values right after parking.
// - Flux from first-order low-pass integrator set by filter coefficient.
module focp_core #(
  parameter longint ZERO_SPEED_LIMIT = focp_pkg::ZERO_SPEED_CYCLES
) (
  input  wire logic                    clk_sys,
  input  wire logic                    reset,
  input  wire logic                    clk_en,
  input  wire focp_pkg::focp_bus_type  bus,
  output logic [15:0]                  rdata,
  input  wire logic                    ctrl_update,
  input  wire focp_pkg::focp_meas_type meas,
  output focp_pkg::focp_ctrl_type      ctrl,
  output logic                         direction_positive,
  output logic signed [23:0]           pll_limited,
  output logic signed [15:0]           flux_alpha,
  output logic signed [15:0]           flux_beta,
  output logic [15:0]                  speed_cmd_clamped,
  output logic                         zero_speed_fault,
  output logic                         irq
);
  import focp_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic signed [15:0] clamp_sym(input logic signed [15:0] v,
                                                   input logic signed [15:0] lim);
    logic signed [15:0] l;
    l = (lim < 0) ? 16'sh0000 : lim;
    if (v > l)
      clamp_sym = l;
    else if (v < -l)
      clamp_sym = -l;
    else
      clamp_sym = v;
  endfunction : clamp_sym

  function automatic logic signed [15:0] lp_step(input logic signed [15:0] f,
                                                 input logic signed [15:0] v,
                                                 input logic [15:0] k);
    logic signed [47:0] d;
    d = (48'(v) - 48'(f)) * $signed({1'b0, k[12:0]});
    lp_step = f + 16'(d >>> FLUX_FILT_SHIFT);
  endfunction : lp_step

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [15:0] angle_advance_gain, alpha_flux_start, beta_flux_start, flux_filter_coefficient;
  logic [15:0] angle_advance_max, flux_lag_compensation, q_axis_output_limit;
  logic [15:0] pll_output_frequency_limit, d_axis_output_limit, torque_current_command;
  logic [15:0] bus_comp_scaler, speed_gain_factor, minimum_speed, direction_select;
  logic [15:0] fault_disable_mask, motor_control_flags, irq_status, irq_mask;
  // Shadows: a write applies from the next control update
  logic [15:0] act_dlim, act_qlim, act_trq, act_min, act_dir, act_pll, act_gain, act_max, act_lag;
  logic [15:0] act_fa, act_fb, act_tau, act_flags, act_fdis;
  logic        park_seen;
  logic [31:0] zero_count;
  logic        zero_event;
  logic        flux_event;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      angle_advance_gain         <= REG_RESET;
      alpha_flux_start           <= REG_RESET;
      beta_flux_start            <= REG_RESET;
      flux_filter_coefficient    <= REG_RESET;
      angle_advance_max          <= REG_RESET;
      flux_lag_compensation      <= REG_RESET;
      q_axis_output_limit        <= REG_RESET;
      pll_output_frequency_limit <= REG_RESET;
      d_axis_output_limit        <= REG_RESET;
      torque_current_command     <= REG_RESET;
      bus_comp_scaler            <= REG_RESET;
      speed_gain_factor          <= REG_RESET;
      minimum_speed              <= REG_RESET;
      direction_select           <= REG_RESET;
      fault_disable_mask         <= REG_RESET;
      motor_control_flags        <= REG_RESET;
      irq_mask                   <= REG_RESET;
    end else if (clk_en && bus.write) begin
      case (bus.addr)
        ADDR_ANGLE_ADVANCE_GAIN:  angle_advance_gain         <= bus.wdata;
        ADDR_ALPHA_FLUX_START:    alpha_flux_start           <= bus.wdata;
        ADDR_BETA_FLUX_START:     beta_flux_start            <= bus.wdata;
        ADDR_FLUX_FILTER_COEFF:   flux_filter_coefficient    <= bus.wdata;
        ADDR_ANGLE_ADVANCE_MAX:   angle_advance_max          <= bus.wdata;
        ADDR_FLUX_LAG_COMP:       flux_lag_compensation      <= bus.wdata;
        ADDR_Q_AXIS_OUTPUT_LIMIT: q_axis_output_limit        <= bus.wdata;
        ADDR_PLL_FREQ_LIMIT:      pll_output_frequency_limit <= bus.wdata;
        ADDR_D_AXIS_OUTPUT_LIMIT: d_axis_output_limit        <= bus.wdata;
        ADDR_TORQUE_CURRENT_CMD:  torque_current_command     <= bus.wdata;
        ADDR_BUS_COMP_SCALER:     bus_comp_scaler            <= bus.wdata;
        ADDR_SPEED_GAIN_FACTOR:   speed_gain_factor          <= bus.wdata;
        ADDR_MINIMUM_SPEED:       minimum_speed              <= bus.wdata;
        ADDR_DIRECTION_SELECT:    direction_select           <= bus.wdata;
        ADDR_FAULT_DISABLE_MASK:  fault_disable_mask         <= bus.wdata;
        ADDR_MOTOR_CONTROL_FLAGS: motor_control_flags        <= bus.wdata;
        ADDR_IRQ_MASK:            irq_mask                   <= bus.wdata;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Parameter shadow, loaded on control update
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      act_dlim  <= REG_RESET;
      act_qlim  <= REG_RESET;
      act_trq   <= REG_RESET;
      act_min   <= REG_RESET;
      act_dir   <= REG_RESET;
      act_pll   <= REG_RESET;
      act_gain  <= REG_RESET;
      act_max   <= REG_RESET;
      act_lag   <= REG_RESET;
      act_fa    <= REG_RESET;
      act_fb    <= REG_RESET;
      act_tau   <= REG_RESET;
      act_flags <= REG_RESET;
      act_fdis  <= REG_RESET;
    end else if (clk_en && ctrl_update) begin
      act_dlim  <= d_axis_output_limit;
      act_qlim  <= q_axis_output_limit;
      act_trq   <= torque_current_command;
      act_min   <= minimum_speed;
      act_dir   <= direction_select;
      act_pll   <= pll_output_frequency_limit;
      act_gain  <= angle_advance_gain;
      act_max   <= angle_advance_max;
      act_lag   <= flux_lag_compensation;
      act_fa    <= alpha_flux_start;
      act_fb    <= beta_flux_start;
      act_tau   <= flux_filter_coefficient;
      act_flags <= motor_control_flags;
      act_fdis  <= fault_disable_mask;
    end
  end

  // ----------------------------------------------------------------
  // Regulator limits, command and angle
  // ----------------------------------------------------------------
  logic signed [15:0] q_lim;
  logic signed [15:0] trq_cmd;
  logic [15:0]        min_speed_rpm;
  logic [2:0]         freq_mult;
  logic signed [39:0] pll_lim_full;
  logic [31:0]        adv_raw;
  logic [15:0]        adv;
  logic signed [31:0] lag_full;

  always_comb begin
    // Smaller of the static and dynamic limits applies, so each bounds the other
    q_lim = (meas.q_dyn_limit < $signed(act_qlim)) ? meas.q_dyn_limit : $signed(act_qlim);
    trq_cmd = $signed(act_trq);
    if (trq_cmd < TORQUE_CMD_MIN)
      trq_cmd = TORQUE_CMD_MIN;
    else if (trq_cmd > TORQUE_CMD_MAX)
      trq_cmd = TORQUE_CMD_MAX;
    min_speed_rpm = 16'((32'(act_min[7:0]) * 32'(meas.top_speed)) >> MIN_SPEED_SHIFT);
    if (act_flags[QUAD_SCALE_BIT])
      freq_mult = 3'd4;
    else if (act_flags[DOUBLE_SCALE_BIT])
      freq_mult = 3'd2;
    else
      freq_mult = 3'd1;
    // Switching frequency and 2^13 live in the count scaling
    pll_lim_full = 40'($signed({1'b0, act_pll[7:0]})) * 40'($signed({1'b0, freq_mult}));
    // At rated current one gain step is two 0.17578 deg counts
    adv_raw = (32'(act_gain[7:0]) * 32'(meas.motor_current < 0 ? -meas.motor_current
                                                               : meas.motor_current)) >> ADV_GAIN_SHIFT;
    adv = (adv_raw > 32'(act_max)) ? act_max : adv_raw[15:0];
    lag_full = 32'(meas.rotor_freq) * $signed({1'b0, act_lag[14:0]});
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ctrl               <= '0;
      direction_positive <= 1'b0;
      pll_limited        <= '0;
      speed_cmd_clamped  <= '0;
    end else if (clk_en) begin
      ctrl.d_out         <= clamp_sym(meas.d_in, $signed(act_dlim));
      ctrl.q_out         <= clamp_sym(meas.q_in, q_lim);
      ctrl.torque_cmd    <= trq_cmd;
      ctrl.current_angle <= meas.rotor_angle + RIGHT_ANGLE + (adv << ADV_MAX_SHIFT);
      ctrl.lag_angle     <= 16'(lag_full >>> PLL_LIMIT_SHIFT);
      direction_positive <= act_dir[0];
      if (meas.pll_integral > 24'(pll_lim_full))
        pll_limited <= 24'(pll_lim_full);
      else if (meas.pll_integral < -24'(pll_lim_full))
        pll_limited <= -24'(pll_lim_full);
      else
        pll_limited <= meas.pll_integral;
      speed_cmd_clamped  <= (meas.speed_cmd < min_speed_rpm) ? min_speed_rpm : meas.speed_cmd;
    end
  end

  // ----------------------------------------------------------------
  // Flux estimator
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      flux_alpha <= '0;
      flux_beta  <= '0;
      park_seen  <= 1'b0;
      flux_event <= 1'b0;
    end else if (clk_en) begin
      park_seen  <= meas.park_done;
      flux_event <= 1'b0;
      if (meas.park_done && !park_seen) begin
        flux_alpha <= 16'($signed(act_fa[7:0]));
        flux_beta  <= 16'($signed(act_fb[7:0]));
        flux_event <= 1'b1;
      end else if (ctrl_update) begin
        flux_alpha <= lp_step(flux_alpha, meas.alpha_volt, act_tau);
        flux_beta  <= lp_step(flux_beta, meas.beta_volt, act_tau);
      end
    end
  end

  // ----------------------------------------------------------------
  // Zero-speed fault
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      zero_count       <= '0;
      zero_speed_fault <= 1'b0;
      zero_event       <= 1'b0;
    end else if (clk_en) begin
      zero_event <= 1'b0;
      if (act_fdis[ZERO_SPEED_DISABLE_BIT] || !meas.running ||
          meas.speed >= (min_speed_rpm >> 1)) begin
        zero_count <= '0;
      end else if (64'(zero_count) < ZERO_SPEED_LIMIT) begin
        zero_count <= zero_count + 32'd1;
      end else if (!zero_speed_fault) begin
        zero_speed_fault <= 1'b1;
        zero_event       <= 1'b1;
      end
      if (!meas.running)
        zero_speed_fault <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts and read-back
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      irq_status <= '0;
      irq        <= 1'b0;
    end else if (clk_en) begin
      // Set beats a simultaneous write-one-to-clear
      irq_status <= (irq_status & ~((bus.write && bus.addr == ADDR_IRQ_STATUS) ? bus.wdata : 16'h0000))
                    | {14'h0000, flux_event, zero_event};
      irq        <= |(irq_status & irq_mask);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rdata <= '0;
    end else if (clk_en) begin
      if (bus.read) begin
        case (bus.addr)
          ADDR_ANGLE_ADVANCE_GAIN:  rdata <= angle_advance_gain;
          ADDR_ALPHA_FLUX_START:    rdata <= alpha_flux_start;
          ADDR_BETA_FLUX_START:     rdata <= beta_flux_start;
          ADDR_FLUX_FILTER_COEFF:   rdata <= flux_filter_coefficient;
          ADDR_ANGLE_ADVANCE_MAX:   rdata <= angle_advance_max;
          ADDR_FLUX_LAG_COMP:       rdata <= flux_lag_compensation;
          ADDR_Q_AXIS_OUTPUT_LIMIT: rdata <= q_axis_output_limit;
          ADDR_PLL_FREQ_LIMIT:      rdata <= pll_output_frequency_limit;
          ADDR_D_AXIS_OUTPUT_LIMIT: rdata <= d_axis_output_limit;
          ADDR_TORQUE_CURRENT_CMD:  rdata <= torque_current_command;
          ADDR_BUS_COMP_SCALER:     rdata <= bus_comp_scaler;
          ADDR_SPEED_GAIN_FACTOR:   rdata <= speed_gain_factor;
          ADDR_MINIMUM_SPEED:       rdata <= minimum_speed;
          ADDR_DIRECTION_SELECT:    rdata <= direction_select;
          ADDR_FAULT_DISABLE_MASK:  rdata <= fault_disable_mask;
          ADDR_MOTOR_CONTROL_FLAGS: rdata <= motor_control_flags;
          ADDR_IRQ_STATUS:          rdata <= irq_status;
          ADDR_IRQ_MASK:            rdata <= irq_mask;
          ADDR_CORE_STATUS:         rdata <= {13'h0000, freq_mult == 3'd4, zero_speed_fault, direction_positive};
          default:                  rdata <= READ_UNMAPPED;
        endcase
      end else begin
        rdata <= '0;
      end
    end
  end

endmodule : focp_core

// *** hdl/focp_pkg.sv ***
package focp_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_ANGLE_ADVANCE_GAIN    = 16'h80B8;
  localparam logic [15:0] ADDR_ALPHA_FLUX_START      = 16'h80D0;
  localparam logic [15:0] ADDR_BETA_FLUX_START       = 16'h80D2;
  localparam logic [15:0] ADDR_FLUX_FILTER_COEFF     = 16'h80D4;
  localparam logic [15:0] ADDR_ANGLE_ADVANCE_MAX     = 16'h80E2;
  localparam logic [15:0] ADDR_FLUX_LAG_COMP         = 16'h814A;
  localparam logic [15:0] ADDR_Q_AXIS_OUTPUT_LIMIT   = 16'h8174;
  localparam logic [15:0] ADDR_PLL_FREQ_LIMIT        = 16'h8254;
  localparam logic [15:0] ADDR_D_AXIS_OUTPUT_LIMIT   = 16'h826E;
  localparam logic [15:0] ADDR_TORQUE_CURRENT_CMD    = 16'h8292;
  localparam logic [15:0] ADDR_BUS_COMP_SCALER       = 16'h82CE;
  localparam logic [15:0] ADDR_SPEED_GAIN_FACTOR     = 16'h8318;
  localparam logic [15:0] ADDR_MINIMUM_SPEED         = 16'h8344;
  localparam logic [15:0] ADDR_DIRECTION_SELECT      = 16'h83D2;
  localparam logic [15:0] ADDR_FAULT_DISABLE_MASK    = 16'h8400;
  localparam logic [15:0] ADDR_MOTOR_CONTROL_FLAGS   = 16'h8402;
  localparam logic [15:0] ADDR_IRQ_STATUS            = 16'h8404;
  localparam logic [15:0] ADDR_IRQ_MASK              = 16'h8406;
  localparam logic [15:0] ADDR_CORE_STATUS           = 16'h8408;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int          ZERO_SPEED_DISABLE_BIT = 5;
  localparam int          QUAD_SCALE_BIT         = 0;
  localparam int          DOUBLE_SCALE_BIT       = 1;
  localparam int          IRQ_ZERO_SPEED_BIT     = 0;
  localparam int          IRQ_FLUX_LOAD_BIT      = 1;
  localparam logic [15:0] REG_RESET              = 16'h0000;
  localparam logic [15:0] READ_UNMAPPED          = 16'h0000;

  // ----------------------------------------------------------------
  // Scaling constants
  // ----------------------------------------------------------------
  localparam logic signed [15:0] FULL_MODULATION  = 16'sh0596;
  localparam logic signed [15:0] TORQUE_CMD_MIN   = -16'sh4000;
  localparam logic signed [15:0] TORQUE_CMD_MAX   = 16'sh3FFF;
  localparam logic [15:0]        RIGHT_ANGLE      = 16'h4000;
  localparam int                 MIN_SPEED_SHIFT  = 11;
  localparam int                 PLL_LIMIT_SHIFT  = 13;
  localparam int                 FLUX_FILT_SHIFT  = 18;
  localparam int                 ADV_GAIN_SHIFT   = 11;
  localparam int                 ADV_MAX_SHIFT    = 5;
  localparam int                 ZERO_SPEED_TIME_S = 2;
  localparam longint             CLK_HZ           = 250000000;
  localparam longint             ZERO_SPEED_CYCLES = ZERO_SPEED_TIME_S * CLK_HZ;

  typedef struct packed {
    logic        write;
    logic        read;
    logic [15:0] addr;
    logic [15:0] wdata;
  } focp_bus_type;

  typedef struct packed {
    logic signed [15:0] d_out;
    logic signed [15:0] q_out;
    logic signed [15:0] torque_cmd;
    logic        [15:0] current_angle;
    logic        [15:0] lag_angle;
  } focp_ctrl_type;

  typedef struct packed {
    logic signed [15:0] d_in;
    logic signed [15:0] q_in;
    logic signed [15:0] q_dyn_limit;
    logic        [15:0] speed;
    logic        [15:0] speed_cmd;
    logic        [15:0] top_speed;
    logic        [15:0] rotor_angle;
    logic signed [15:0] motor_current;
    logic signed [15:0] rotor_freq;
    logic signed [23:0] pll_integral;
    logic signed [15:0] alpha_volt;
    logic signed [15:0] beta_volt;
    logic               park_done;
    logic               running;
  } focp_meas_type;

  typedef enum logic [1:0] {
    FOCP_IDLE    = 2'b00,
    FOCP_PARKING = 2'b01,
    FOCP_RUNNING = 2'b10
  } focp_phase_type;

endpackage : focp_pkg

// *** tb/focp_core_asserts.sv ***
`timescale 1ns/1ns
module focp_core_asserts #(
  parameter longint ZERO_SPEED_LIMIT = 20
) (
  input wire logic                    clk_sys,
  input wire logic                    reset,
  input wire logic                    clk_en,
  input wire focp_pkg::focp_bus_type  bus,
  input wire logic [15:0]             rdata,
  input wire logic                    ctrl_update,
  input wire focp_pkg::focp_meas_type meas,
  input wire focp_pkg::focp_ctrl_type ctrl,
  input wire logic                    direction_positive,
  input wire logic signed [23:0]      pll_limited,
  input wire logic signed [15:0]      flux_alpha,
  input wire logic signed [15:0]      flux_beta,
  input wire logic [15:0]             speed_cmd_clamped,
  input wire logic                    zero_speed_fault,
  input wire logic                    irq
);
  import focp_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Saturating, so a stuck run cannot wrap and hide an early fault
  logic [31:0] run_cnt;
  always_ff @(posedge clk_sys) begin
    if (reset || !meas.running) begin
      run_cnt <= '0;
    end else if (clk_en && run_cnt != 32'hFFFFFFFF) begin
      run_cnt <= run_cnt + 32'h1;
    end
  end
  property p_rdata_idle;
    $past(clk_en) && !$past(bus.read) |-> rdata == 16'h0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("rdata set without read");
  property p_dir_update;
    $changed(direction_positive) |-> $past(ctrl_update, 2);
  endproperty
  a_dir_update: assert property (p_dir_update) else $error("direction moved without update");
  property p_torque_range;
    ctrl.torque_cmd >= TORQUE_CMD_MIN && ctrl.torque_cmd <= TORQUE_CMD_MAX;
  endproperty
  a_torque_range: assert property (p_torque_range) else $error("torque command out of range");
  property p_d_clamp;
    $past(clk_en) |-> (($past(meas.d_in) < 0) ? (ctrl.d_out <= 0 && ctrl.d_out >= $past(meas.d_in))
                                               : (ctrl.d_out >= 0 && ctrl.d_out <= $past(meas.d_in)));
  endproperty
  a_d_clamp: assert property (p_d_clamp) else $error("d output beyond input");
  property p_q_dyn;
    $past(clk_en) && $past(meas.q_dyn_limit) >= 0
      |-> ctrl.q_out <= $past(meas.q_dyn_limit) && ctrl.q_out >= -$past(meas.q_dyn_limit);
  endproperty
  a_q_dyn: assert property (p_q_dyn) else $error("q output beyond dynamic limit");
  property p_pll_clamp;
    $past(clk_en) |-> (($past(meas.pll_integral) < 0) ? (pll_limited <= 0 && pll_limited >= $past(meas.pll_integral))
                                                      : (pll_limited >= 0 && pll_limited <= $past(meas.pll_integral)));
  endproperty
  a_pll_clamp: assert property (p_pll_clamp) else $error("pll output beyond integral");
  property p_speed_floor;
    $past(clk_en) |-> speed_cmd_clamped >= $past(meas.speed_cmd);
  endproperty
  a_speed_floor: assert property (p_speed_floor) else $error("speed command lowered");
  property p_fault_stop;
    !$past(meas.running) && !$past(meas.running, 2) |-> !zero_speed_fault;
  endproperty
  a_fault_stop: assert property (p_fault_stop) else $error("fault while stopped");
  property p_fault_delay;
    $rose(zero_speed_fault) |-> longint'(run_cnt) >= ZERO_SPEED_LIMIT;
  endproperty
  a_fault_delay: assert property (p_fault_delay) else $error("fault too early");
endmodule : focp_core_asserts

bind focp_core focp_core_asserts #(.ZERO_SPEED_LIMIT(ZERO_SPEED_LIMIT)) u_focp_core_asserts (.*);

// *** tb/focp_motor_model.sv ***
`timescale 1ns/1ns
module focp_motor_model (
  input  wire logic                    clk_sys,
  input  wire focp_pkg::focp_meas_type plan,
  output focp_pkg::focp_meas_type      meas
);
  import focp_pkg::*;
  // Answers one cycle late, passing the plan through to meas unchanged
  always_ff @(posedge clk_sys) begin
    meas <= plan;
  end
endmodule : focp_motor_model

// *** tb/foc_regulator_estimator_params_tb.sv ***
`timescale 1ns/1ns
module foc_regulator_estimator_params_tb;
  import focp_pkg::*;
  localparam logic [15:0] REGS [14] = '{ADDR_ANGLE_ADVANCE_GAIN, ADDR_ALPHA_FLUX_START, ADDR_BETA_FLUX_START,
    ADDR_FLUX_FILTER_COEFF, ADDR_ANGLE_ADVANCE_MAX, ADDR_FLUX_LAG_COMP, ADDR_Q_AXIS_OUTPUT_LIMIT, ADDR_PLL_FREQ_LIMIT,
    ADDR_D_AXIS_OUTPUT_LIMIT, ADDR_TORQUE_CURRENT_CMD, ADDR_BUS_COMP_SCALER, ADDR_SPEED_GAIN_FACTOR,
    ADDR_MINIMUM_SPEED, ADDR_DIRECTION_SELECT};
  localparam int MULT [4] = '{1, 4, 2, 4};
  logic               clk_sys = 1'b0;
  logic               reset = 1'b1;
  logic               clk_en = 1'b1;
  logic               ctrl_update = 1'b0;
  focp_bus_type       bus = '0;
  focp_meas_type      plan = '0;
  focp_meas_type      meas;
  focp_ctrl_type      ctrl;
  logic [15:0]        rdata, speed_cmd_clamped;
  logic               direction_positive, zero_speed_fault, irq;
  logic signed [23:0] pll_limited;
  logic signed [15:0] flux_alpha, flux_beta;
  int                 n_fail = 0, check_count = 0;
  always #2 clk_sys = ~clk_sys;
  focp_core #(.ZERO_SPEED_LIMIT(20)) u_focp_core (.*);
  focp_motor_model u_focp_motor_model (.clk_sys(clk_sys), .plan(plan), .meas(meas));
  // ----------------------------------------------------------------
  // Bus and compare helpers
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // Spare edge after each strobe: one assignment per signal per step
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    bus <= '{1'b1, 1'b0, a, d};
    @(posedge clk_sys);
    bus.write <= 1'b0;
    @(posedge clk_sys);
  endtask : wr
  task automatic rdchk(input logic [15:0] a, input logic [15:0] e);
    bus <= '{1'b0, 1'b1, a, 16'h0000};
    @(posedge clk_sys);
    bus.read <= 1'b0;
    #1;
    chk("rdata", e, rdata);
    @(posedge clk_sys);
  endtask : rdchk
  task automatic upd();
    ctrl_update <= 1'b1;
    @(posedge clk_sys);
    ctrl_update <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask : upd
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    for (int i = 0; i < 14; i++) rdchk(REGS[i], REG_RESET);
    for (int i = 0; i < 14; i++) wr(REGS[i], 16'h0A50 + 16'(i));
    for (int i = 0; i < 14; i++) rdchk(REGS[i], 16'h0A50 + 16'(i));
    wr(16'h8000, 16'h1234);
    rdchk(16'h8000, READ_UNMAPPED);
    wr(ADDR_BUS_COMP_SCALER, 16'h00D5);
  endtask : t_regs
  task automatic t_limits();
    wr(ADDR_D_AXIS_OUTPUT_LIMIT, 16'h0596);
    wr(ADDR_Q_AXIS_OUTPUT_LIMIT, 16'h0100);
    plan.d_in <= 16'sh07D0;
    plan.q_in <= 16'sh03E8;
    plan.q_dyn_limit <= 16'sh0200;
    upd();
    chk("d_out", 16'sh0596, ctrl.d_out);
    chk("q_out", 16'sh0100, ctrl.q_out);
    plan.d_in <= 16'shF830;
    plan.q_in <= 16'shFC18;
    plan.q_dyn_limit <= 16'sh0080;
    upd();
    chk("d_out", 16'shFA6A, ctrl.d_out);
    chk("q_out", 16'shFF80, ctrl.q_out);
  endtask : t_limits
  task automatic t_dir_torque();
    for (int v = 1; v >= 0; v--) begin
      wr(ADDR_DIRECTION_SELECT, 16'(v));
      wr(ADDR_TORQUE_CURRENT_CMD, v ? 16'h8000 : 16'h7FFF);
      upd();
      chk("direction", 24'(v), 24'(direction_positive));
      chk("torque", v ? 16'shC000 : 16'sh3FFF, ctrl.torque_cmd);
    end
  endtask : t_dir_torque
  task automatic t_speed();
    wr(ADDR_MINIMUM_SPEED, 16'h0064);
    plan.top_speed <= 16'h0800;
    plan.speed_cmd <= 16'h0032;
    upd();
    chk("speed_cmd", 16'h0064, speed_cmd_clamped);
    plan.speed_cmd <= 16'h012C;
    upd();
    chk("speed_cmd", 16'h012C, speed_cmd_clamped);
  endtask : t_speed
  task automatic t_pll();
    wr(ADDR_PLL_FREQ_LIMIT, 16'h000A);
    plan.pll_integral <= 24'sh0003E8;
    for (int f = 0; f < 4; f++) begin
      wr(ADDR_MOTOR_CONTROL_FLAGS, 16'(f));
      upd();
      chk("pll", 24'h00000A * 24'(MULT[f]), pll_limited);
    end
  endtask : t_pll
  task automatic t_angle();
    logic [15:0] gain [3];
    logic [15:0] exp [3];
    gain = '{16'h0000, 16'h00FF, 16'h0010};
    exp = '{16'h5000, 16'h5C80, 16'h53E0};
    wr(ADDR_ANGLE_ADVANCE_MAX, 16'h0064);
    wr(ADDR_FLUX_LAG_COMP, 16'h2000);
    plan.rotor_angle <= 16'h1000;
    plan.motor_current <= 16'sh0FFF;
    plan.rotor_freq <= 16'sh0800;
    for (int k = 0; k < 3; k++) begin
      wr(ADDR_ANGLE_ADVANCE_GAIN, gain[k]);
      upd();
      chk("current_angle", exp[k], ctrl.current_angle);
    end
    chk("lag_angle", 16'h0800, ctrl.lag_angle);
  endtask : t_angle
  task automatic t_flux();
    wr(ADDR_ALPHA_FLUX_START, 16'h0080);
    wr(ADDR_BETA_FLUX_START, 16'h004E);
    wr(ADDR_FLUX_FILTER_COEFF, 16'h1FFF);
    wr(ADDR_IRQ_MASK, 16'h0002);
    upd();
    plan.park_done <= 1'b1;
    repeat (5) @(posedge clk_sys);
    chk("flux_alpha", 16'shFF80, flux_alpha);
    chk("flux_beta", 16'sh004E, flux_beta);
    chk("irq", 24'h000001, 24'(irq));
    rdchk(ADDR_IRQ_STATUS, 16'h0002);
    wr(ADDR_IRQ_STATUS, 16'h0002);
    repeat (2) @(posedge clk_sys);
    chk("irq", 24'h000000, 24'(irq));
    plan.alpha_volt <= 16'sh4000;
    @(posedge clk_sys);
    upd();
    chk("flux_alpha", 16'sh0183, flux_alpha);
    chk("flux_beta", 16'sh004B, flux_beta);
  endtask : t_flux
  task automatic t_zero();
    int i;
    wr(ADDR_FAULT_DISABLE_MASK, 16'h0020);
    plan.speed <= 16'h000A;
    plan.running <= 1'b1;
    upd();
    repeat (40) @(posedge clk_sys);
    chk("fault", 24'h000000, 24'(zero_speed_fault));
    plan.running <= 1'b0;
    wr(ADDR_FAULT_DISABLE_MASK, 16'h0000);
    upd();
    plan.running <= 1'b1;
    for (i = 0; i < 40 && zero_speed_fault !== 1'b1; i++) @(posedge clk_sys);
    if (i == 40) begin
      n_fail++;
      return;
    end
    chk("fault delay", 24'h000001, 24'(i >= 20));
    chk("irq", 24'h000000, 24'(irq));
    wr(ADDR_IRQ_MASK, 16'h0003);
    @(posedge clk_sys);
    chk("irq", 24'h000001, 24'(irq));
    rdchk(ADDR_IRQ_STATUS, 16'h0001);
    rdchk(ADDR_CORE_STATUS, 16'h0006);
    plan.running <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk("fault", 24'h000000, 24'(zero_speed_fault));
    wr(ADDR_IRQ_STATUS, 16'h0001);
    repeat (2) @(posedge clk_sys);
    chk("irq", 24'h000000, 24'(irq));
  endtask : t_zero
  initial begin
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    t_regs();
    t_limits();
    t_dir_torque();
    t_speed();
    t_pll();
    t_angle();
    t_flux();
    t_zero();
    close_out();
  end
endmodule : foc_regulator_estimator_params_tb
